/* design/bit_and_branch_instr_exec.sv */
// Overview of operation
// - Bit clear zeroes selected bit, flags untouched
// - Bit set ones selected bit, flags untouched
// - Skip-if-clear flushes next when bit zero
// - Skip-if-set flushes next when bit one
// - Branch to next address plus signed literal
// - Literal offset spans minus 256 to 255
// - Register branch adds unsigned working register
// - Three-bit bit number, seven-bit file address
module bit_and_branch_instr_exec #(
    parameter int PC_W = bit_branch_pkg::PC_W
) (
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              instr_valid,
    input  wire logic [bit_branch_pkg::INSTR_W-1:0] instr,
    input  wire logic [bit_branch_pkg::DATA_W-1:0]  w_reg,
    output logic      [PC_W-1:0]                    pc_q,
    output logic                                   fetch_ready_q,
    output logic                                   flush_q,
    output logic                                   busy_q,
    output logic                                   wr_en_q,
    output logic      [bit_branch_pkg::FILE_W-1:0]  wr_addr_q,
    output logic      [bit_branch_pkg::DATA_W-1:0]  wr_data_q,
    output logic                                   status_we_q
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic bit_branch_pkg::decoded_t decode(input logic [13:0] iw);
        bit_branch_pkg::decoded_t d;
        d           = '0;
        d.op        = bit_branch_pkg::OP_NONE;
        d.file_addr = iw[bit_branch_pkg::FILE_LSB +: bit_branch_pkg::FILE_W];
        d.bit_num   = iw[bit_branch_pkg::BIT_LSB +: bit_branch_pkg::BIT_W];
        d.offset    = iw[bit_branch_pkg::BRA_K_LSB +: bit_branch_pkg::BRA_K_W];
        if (iw == bit_branch_pkg::OPC_REG_BRANCH) begin
            d.op = bit_branch_pkg::OP_REG_BRANCH;
        end else if (iw[13:9] == bit_branch_pkg::OPC_REL_BRANCH) begin
            d.op = bit_branch_pkg::OP_REL_BRANCH;
        end else begin
            case (iw[13:10])
                bit_branch_pkg::OPC_BIT_CLEAR:  d.op = bit_branch_pkg::OP_BIT_CLEAR;
                bit_branch_pkg::OPC_BIT_SET:    d.op = bit_branch_pkg::OP_BIT_SET;
                bit_branch_pkg::OPC_SKIP_CLEAR: d.op = bit_branch_pkg::OP_SKIP_CLEAR;
                bit_branch_pkg::OPC_SKIP_SET:   d.op = bit_branch_pkg::OP_SKIP_SET;
                default:                        d.op = bit_branch_pkg::OP_NONE;
            endcase
        end
        return d;
    endfunction : decode

    // One-hot mask for a bit number, bit 0 is the LSB
    function automatic logic [7:0] bit_mask(input logic [2:0] b);
        return 8'h01 << b;
    endfunction : bit_mask

    typedef enum {ST_FETCH, ST_READ, ST_EXEC, ST_FLUSH} state_t;

    state_t                   state_q;
    bit_branch_pkg::decoded_t dec_q;
    logic [PC_W-1:0]          next_pc;
    logic [7:0]               rd_data;
    logic                     bit_val;
    logic [PC_W-1:0]          lit_ext;
    logic [PC_W-1:0]          w_ext;

    assign next_pc = pc_q + PC_W'(1);
    // Sign extend the 9-bit literal, giving reach -256..+255
    assign lit_ext = PC_W'({{(PC_W-9){dec_q.offset[8]}}, dec_q.offset});
    assign w_ext   = PC_W'({{(PC_W-8){1'b0}}, w_reg});
    assign bit_val = |(rd_data & bit_mask(dec_q.bit_num));

    // ------------------------------------------------------------------
    // File register storage
    // ------------------------------------------------------------------
    file_reg_mem #(
        .DEPTH  (bit_branch_pkg::FILE_DEPTH),
        .ADDR_W (bit_branch_pkg::FILE_W),
        .DATA_W (bit_branch_pkg::DATA_W)
    ) u_mem (
        .clk     (clk),
        .rd_addr (dec_q.file_addr),
        .rd_data (rd_data),
        .wr_en   (wr_en_q),
        .wr_addr (wr_addr_q),
        .wr_data (wr_data_q)
    );

    // Sequencer: fetch, read operand, execute, optional flush cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_FETCH;
            dec_q   <= '0;
        end else begin
            case (state_q)
                ST_FETCH: begin
                    if (instr_valid) begin
                        dec_q   <= decode(instr);
                        state_q <= ST_READ;
                    end
                end
                ST_READ:  state_q <= ST_EXEC;
                ST_EXEC: begin
                    case (dec_q.op)
                        bit_branch_pkg::OP_SKIP_CLEAR: state_q <= bit_val ? ST_FETCH : ST_FLUSH;
                        bit_branch_pkg::OP_SKIP_SET:   state_q <= bit_val ? ST_FLUSH : ST_FETCH;
                        bit_branch_pkg::OP_REL_BRANCH,
                        bit_branch_pkg::OP_REG_BRANCH: state_q <= ST_FLUSH;
                        default:                       state_q <= ST_FETCH;
                    endcase
                end
                ST_FLUSH: state_q <= ST_FETCH;
                default:  state_q <= ST_FETCH;
            endcase
        end
    end

    // Program counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_q <= bit_branch_pkg::PC_RESET[PC_W-1:0];
        end else if (state_q == ST_EXEC) begin
            case (dec_q.op)
                bit_branch_pkg::OP_REL_BRANCH: pc_q <= next_pc + lit_ext;
                bit_branch_pkg::OP_REG_BRANCH: pc_q <= next_pc + w_ext;
                default:                       pc_q <= next_pc;
            endcase
        end else if (state_q == ST_FLUSH && (dec_q.op == bit_branch_pkg::OP_SKIP_CLEAR ||
                                             dec_q.op == bit_branch_pkg::OP_SKIP_SET)) begin
            pc_q <= next_pc; // Skipped word still advances the counter
        end
    end

    // Read-modify-write of the addressed file register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_en_q   <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= '0;
        end else begin
            wr_en_q <= 1'b0;
            if (state_q == ST_EXEC) begin
                wr_addr_q <= dec_q.file_addr;
                if (dec_q.op == bit_branch_pkg::OP_BIT_CLEAR) begin
                    wr_en_q   <= 1'b1;
                    wr_data_q <= rd_data & ~bit_mask(dec_q.bit_num);
                end else if (dec_q.op == bit_branch_pkg::OP_BIT_SET) begin
                    wr_en_q   <= 1'b1;
                    wr_data_q <= rd_data | bit_mask(dec_q.bit_num);
                end
            end
        end
    end

    // Handshake and flush indication; status flags never written here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetch_ready_q <= 1'b0;
            flush_q       <= 1'b0;
            busy_q        <= 1'b0;
            status_we_q   <= 1'b0;
        end else begin
            fetch_ready_q <= (state_q == ST_FETCH) && !instr_valid;
            flush_q       <= (state_q == ST_EXEC) && (dec_q.op != bit_branch_pkg::OP_BIT_CLEAR) &&
                             (dec_q.op != bit_branch_pkg::OP_BIT_SET) && (dec_q.op != bit_branch_pkg::OP_NONE) &&
                             !((dec_q.op == bit_branch_pkg::OP_SKIP_CLEAR) && bit_val) &&
                             !((dec_q.op == bit_branch_pkg::OP_SKIP_SET) && !bit_val);
            busy_q        <= !(state_q == ST_FETCH && !instr_valid);
            status_we_q   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_clear_bit_zero: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_EXEC && dec_q.op == bit_branch_pkg::OP_BIT_CLEAR)
        |=> wr_en_q && !wr_data_q[$past(dec_q.bit_num)]
            && ((wr_data_q | bit_mask($past(dec_q.bit_num))) === ($past(rd_data) | bit_mask($past(dec_q.bit_num)))))
        else $error("bit clear result wrong");
    a_set_bit_one: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_EXEC && dec_q.op == bit_branch_pkg::OP_BIT_SET)
        |=> wr_en_q && wr_data_q === ($past(rd_data) | bit_mask($past(dec_q.bit_num))))
        else $error("bit set result wrong");
    a_skip_clear_flush: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_EXEC && dec_q.op == bit_branch_pkg::OP_SKIP_CLEAR)
        |=> flush_q == !$past(bit_val))
        else $error("skip if clear flush wrong");
    a_skip_set_flush: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_EXEC && dec_q.op == bit_branch_pkg::OP_SKIP_SET)
        |=> flush_q == $past(bit_val))
        else $error("skip if set flush wrong");
    a_rel_branch_pc: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_EXEC && dec_q.op == bit_branch_pkg::OP_REL_BRANCH)
        |=> pc_q == PC_W'($past(pc_q) + PC_W'(1) + $past(lit_ext)) ##1 state_q == ST_FETCH)
        else $error("relative branch target wrong");
    a_rel_branch_range: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_EXEC && dec_q.op == bit_branch_pkg::OP_REL_BRANCH)
        |=> $signed(PC_W'(pc_q - $past(pc_q) - PC_W'(1))) >= -256
            && $signed(PC_W'(pc_q - $past(pc_q) - PC_W'(1))) <= 255)
        else $error("branch offset outside range");
    a_reg_branch_pc: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_EXEC && dec_q.op == bit_branch_pkg::OP_REG_BRANCH)
        |=> pc_q == PC_W'($past(pc_q) + PC_W'(1) + PC_W'($past(w_reg))) && flush_q)
        else $error("register branch target wrong");
    a_field_decode: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_FETCH && instr_valid)
        |=> dec_q.bit_num == $past(instr[9:7]) && dec_q.file_addr == $past(instr[6:0]))
        else $error("field decode wrong");
    a_no_status_write: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_EXEC && dec_q.op == bit_branch_pkg::OP_BIT_SET && dec_q.bit_num == 3'h7)
        |=> wr_data_q[7] && !status_we_q)
        else $error("bit seven not msb");

endmodule : bit_and_branch_instr_exec

/* design/bit_branch_pkg.sv */
package bit_branch_pkg;

    // ------------------------------------------------------------------
    // Instruction word layout
    // ------------------------------------------------------------------
    localparam int INSTR_W    = 14;
    localparam int PC_W       = 15;
    localparam int FILE_W     = 7;
    localparam int BIT_W      = 3;
    localparam int DATA_W     = 8;
    localparam int BRA_K_W    = 9;
    localparam int FILE_LSB   = 0;
    localparam int BIT_LSB    = 7;
    localparam int BRA_K_LSB  = 0;
    localparam int FILE_DEPTH = 128;

    // Opcode patterns (bits 13:10 for bit ops, 13:9 for branch, full word for register branch)
    localparam logic [3:0]  OPC_BIT_CLEAR  = 4'h4;
    localparam logic [3:0]  OPC_BIT_SET    = 4'h5;
    localparam logic [3:0]  OPC_SKIP_CLEAR = 4'h6;
    localparam logic [3:0]  OPC_SKIP_SET   = 4'h7;
    localparam logic [4:0]  OPC_REL_BRANCH = 5'h19;
    localparam logic [13:0] OPC_REG_BRANCH = 14'h000B;
    localparam logic [13:0] NOP_WORD       = 14'h0000;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [14:0] PC_RESET       = 15'h0000;
    localparam logic [7:0]  W_RESET        = 8'h00;
    localparam int          FLUSH_CYCLES   = 1;

    typedef enum logic [2:0] {
        OP_NONE, OP_BIT_CLEAR, OP_BIT_SET, OP_SKIP_CLEAR, OP_SKIP_SET, OP_REL_BRANCH, OP_REG_BRANCH
    } op_t;

    // Decoded instruction fields travel together
    typedef struct packed {
        op_t                op;
        logic [6:0]         file_addr;
        logic [2:0]         bit_num;
        logic [8:0]         offset;
    } decoded_t;

endpackage : bit_branch_pkg

/* design/file_reg_mem.sv */
module file_reg_mem #(
    parameter int DEPTH  = 128,
    parameter int ADDR_W = 7,
    parameter int DATA_W = 8
) (
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data
);

    logic [DATA_W-1:0] mem [DEPTH];

    // Registered read, plain write port
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule : file_reg_mem

/* dv/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and stimulus rows
    // ------------------------------------------------------------
    typedef struct {
        logic [13:0] word;
        logic [7:0]  w;
        logic        flush;
        logic [14:0] step;
    } row_t;

    logic        clk         = 1'b0;
    logic        rst         = 1'b1;
    logic        instr_valid = 1'b0;
    logic [13:0] instr       = 14'h0000;
    logic [7:0]  w_reg       = 8'h00;
    logic [14:0] pc_q;
    logic        fetch_ready_q;
    logic        flush_q;
    logic        busy_q;
    logic        wr_en_q;
    logic [6:0]  wr_addr_q;
    logic [7:0]  wr_data_q;
    logic        status_we_q;
    int          bad_count   = 0;
    int          check_count = 0;
    int          cyc         = 0;
    logic [7:0]  mem_m [128];
    logic [7:0]  known [128];
    logic [14:0] pc_m = 15'h0000;
    row_t        rows [$];

    bit_and_branch_instr_exec uut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .w_reg(w_reg), .pc_q(pc_q), .fetch_ready_q(fetch_ready_q), .flush_q(flush_q), .busy_q(busy_q),
        .wr_en_q(wr_en_q), .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q), .status_we_q(status_we_q));

    // Clock and hang guard
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            bad_count++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
        check_count++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            bad_count++;
        end
    endtask : chk

    task automatic wait_ready;
        int n;
        n = 0;
        while (fetch_ready_q !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        chk("fetch_ready", 16'h0001, 16'(fetch_ready_q));
    endtask : wait_ready

    task automatic take(input logic [13:0] word, input logic [7:0] w);
        instr       = word;
        w_reg       = w;
        instr_valid = 1'b1;
        @(posedge clk);
        @(negedge clk);
        instr_valid = 1'b0;
    endtask : take

    task automatic run_row(input row_t r);
        logic [3:0] opc;
        logic [6:0] f;
        logic [2:0] b;
        logic       is_bit;
        opc    = r.word[13:10];
        f      = r.word[6:0];
        b      = r.word[9:7];
        is_bit = (opc == bit_branch_pkg::OPC_BIT_SET) || (opc == bit_branch_pkg::OPC_BIT_CLEAR);
        wait_ready();
        take(r.word, r.w);
        chk("busy", 16'h0001, 16'(busy_q));
        chk("fetch_ready_low", 16'h0000, 16'(fetch_ready_q));
        repeat (2) @(posedge clk);
        @(negedge clk);
        if (is_bit) begin
            mem_m[f][b] = (opc == bit_branch_pkg::OPC_BIT_SET);
            known[f][b] = 1'b1;
            chk("wr_addr", 16'(f), 16'(wr_addr_q));
            chk("wr_data", 16'(mem_m[f] & known[f]), 16'(wr_data_q & known[f]));
        end
        chk("wr_en", 16'(is_bit), 16'(wr_en_q));
        chk("flush", 16'(r.flush), 16'(flush_q));
        chk("status_we", 16'h0000, 16'(status_we_q));
        pc_m = pc_m + r.step;
        wait_ready();
        chk("pc", 16'(pc_m), 16'(pc_q));
        $display("test word %h done", r.word);
    endtask : run_row

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        foreach (known[i]) begin
            known[i] = 8'h00;
        end
        for (int i = 0; i < 8; i++) begin
            rows.push_back('{{bit_branch_pkg::OPC_BIT_SET, 3'(i), 7'h55}, 8'h00, 1'b0, 15'h0001});
        end
        rows.push_back('{{bit_branch_pkg::OPC_BIT_CLEAR, 3'h0, 7'h55}, 8'h00, 1'b0, 15'h0001});
        rows.push_back('{{bit_branch_pkg::OPC_BIT_CLEAR, 3'h7, 7'h55}, 8'h00, 1'b0, 15'h0001});
        rows.push_back('{{bit_branch_pkg::OPC_SKIP_CLEAR, 3'h0, 7'h55}, 8'h00, 1'b1, 15'h0002});
        rows.push_back('{{bit_branch_pkg::OPC_SKIP_CLEAR, 3'h1, 7'h55}, 8'h00, 1'b0, 15'h0001});
        rows.push_back('{{bit_branch_pkg::OPC_SKIP_SET, 3'h1, 7'h55}, 8'h00, 1'b1, 15'h0002});
        rows.push_back('{{bit_branch_pkg::OPC_SKIP_SET, 3'h7, 7'h55}, 8'h00, 1'b0, 15'h0001});
        rows.push_back('{{bit_branch_pkg::OPC_BIT_SET, 3'h3, 7'h7f}, 8'h00, 1'b0, 15'h0001});
        // Unknown word only advances the counter
        rows.push_back('{bit_branch_pkg::NOP_WORD, 8'h00, 1'b0, 15'h0001});
        rows.push_back('{{bit_branch_pkg::OPC_REL_BRANCH, 9'h0ff}, 8'h00, 1'b1, 15'h0100});
        rows.push_back('{{bit_branch_pkg::OPC_REL_BRANCH, 9'h100}, 8'h00, 1'b1, 15'h7f01});
        rows.push_back('{{bit_branch_pkg::OPC_REL_BRANCH, 9'h1ff}, 8'h00, 1'b1, 15'h0000});
        rows.push_back('{bit_branch_pkg::OPC_REG_BRANCH, 8'hff, 1'b1, 15'h0100});
        rows.push_back('{bit_branch_pkg::OPC_REG_BRANCH, 8'h00, 1'b1, 15'h0001});
        repeat (2) @(negedge clk);
        rst = 1'b0;
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        // Reset in the middle of a bit set: no write may follow
        wait_ready();
        take({bit_branch_pkg::OPC_BIT_SET, 3'h2, 7'h01}, 8'h00);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        chk("rst_pc", 16'h0000, 16'(pc_q));
        chk("rst_busy", 16'h0000, 16'(busy_q));
        rst = 1'b0;
        pc_m = 15'h0000;
        repeat (3) begin
            @(negedge clk);
            chk("rst_wr_en", 16'h0000, 16'(wr_en_q));
        end
        $display("test mid-run reset done");
        run_row('{{bit_branch_pkg::OPC_BIT_SET, 3'h6, 7'h00}, 8'h00, 1'b0, 15'h0001});
        results();
    end

endmodule : tb_top
